/* pfu_pkg.sv */
package pfu_pkg;

  // clock and time base
  localparam int unsigned CLK_NS      = 25;
  localparam int unsigned TS_RES_NS   = 1_000_000;              // time stamp resolution, 1 ms
  localparam int unsigned TS_CYC      = TS_RES_NS / CLK_NS;     // clocks per millisecond
  localparam int unsigned CYC_MS      = 5;                      // processing cycle in ms
  localparam logic [2:0]  CYC_LAST    = 3'(CYC_MS - 1);

  // thresholds in hundredths of power factor
  localparam logic [6:0]  THR_MIN       = 7'h05;
  localparam logic [6:0]  THR_MAX       = 7'h63;                // 0.99
  localparam logic [6:0]  TRIP_THR_RST  = 7'h50;                // 0.80
  localparam logic [6:0]  ALARM_THR_RST = 7'h5A;                // 0.90
  localparam logic [15:0] PCT_FULL      = 16'h0064;             // 100 %
  localparam logic [15:0] PCT_RELEASE   = 16'h0067;             // 103 %

  // delays in processing cycles
  localparam int unsigned DLY_MAX_MS  = 1_800_000;
  localparam logic [19:0] DLY_MAX     = 20'(DLY_MAX_MS / CYC_MS);
  localparam logic [19:0] DLY_RST     = 20'h00000;

  // mode and event keep reset values
  localparam logic        MODE_RST     = 1'b1;                  // trips and alarms
  localparam logic        KEEP_ON_RST  = 1'b1;
  localparam logic        KEEP_OFF_RST = 1'b1;

  // pre-trigger history
  localparam int unsigned PRE_SHORT_MS = 20;
  localparam int unsigned PRE_LONG_MS  = 200;
  localparam int unsigned PRE_SHORT    = PRE_SHORT_MS / CYC_MS;
  localparam int unsigned HIST_DEPTH   = PRE_LONG_MS / CYC_MS;
  localparam int unsigned REC_DEPTH    = 12;
  localparam logic [3:0]  REC_LAST     = 4'(REC_DEPTH - 1);

  // register offsets
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_TRIP_THR  = 8'h04;
  localparam logic [7:0] OFS_ALARM_THR = 8'h08;
  localparam logic [7:0] OFS_TRIP_DLY  = 8'h0C;
  localparam logic [7:0] OFS_ALARM_DLY = 8'h10;
  localparam logic [7:0] OFS_REL_DLY   = 8'h14;
  localparam logic [7:0] OFS_STATUS    = 8'h18;
  localparam logic [7:0] OFS_RATIO     = 8'h1C;
  localparam logic [7:0] OFS_TRIP_REM  = 8'h20;
  localparam logic [7:0] OFS_ALARM_REM = 8'h24;
  localparam logic [7:0] OFS_CNT0      = 8'h28;                 // five counters, one word each
  localparam logic [7:0] OFS_CNT_CLR   = 8'h3C;
  localparam logic [7:0] OFS_REC_SEL   = 8'h40;
  localparam logic [7:0] OFS_REC_TS    = 8'h44;
  localparam logic [7:0] OFS_REC_PF    = 8'h48;
  localparam logic [7:0] OFS_REC_REM   = 8'h4C;

  // control field positions
  localparam int unsigned CTRL_MODE     = 0;
  localparam int unsigned CTRL_KEEP_ON  = 1;
  localparam int unsigned CTRL_KEEP_OFF = 2;

  // status codes
  localparam logic [2:0] ST_NORMAL  = 3'h0;
  localparam logic [2:0] ST_START   = 3'h1;
  localparam logic [2:0] ST_TRIP    = 3'h2;
  localparam logic [2:0] ST_BLOCKED = 3'h3;
  localparam logic [2:0] ST_ASTART  = 3'h4;
  localparam logic [2:0] ST_ALARM   = 3'h5;

  // output bit positions and record event names
  localparam int unsigned O_ASTART = 0;
  localparam int unsigned O_ALARM  = 1;
  localparam int unsigned O_START  = 2;
  localparam int unsigned O_TRIP   = 3;
  localparam int unsigned O_BLK    = 4;
  localparam logic [1:0] REC_START   = 2'h1;
  localparam logic [1:0] REC_TRIP    = 2'h2;
  localparam logic [1:0] REC_BLOCKED = 2'h3;
  localparam logic [1:0] FAULT_3PH   = 2'h3;

  typedef struct packed {
    logic blocked;
    logic trip;
    logic start;
    logic alarm;
    logic alarm_start;
  } pfu_outs_t;

  typedef struct packed {
    logic        valid;
    logic [4:0]  on;
    logic [4:0]  off;
    logic [31:0] ms;
    logic [7:0]  pf;
    logic [1:0]  fault;
  } pfu_evt_t;

  typedef struct packed {
    logic        pick;
    logic        strt;
    logic        op;
    logic        blk;
    logic [19:0] cnt;
    logic [19:0] rel;
  } pfu_path_t;

  typedef struct packed {
    logic [31:0] ms;
    logic [1:0]  name;
    logic [2:0]  pset;
    logic [7:0]  pf_pre;
    logic [7:0]  pf_now;
    logic [7:0]  pf_long;
    logic [19:0] rem;
  } pfu_rec_t;

endpackage : pfu_pkg

/* pfu_low_pf_stage.sv */
// Local design decisions: the placing of the registers and the address-and-strobe port.
module pfu_low_pf_stage
  import pfu_pkg::*;
#(
  parameter int unsigned MS_CYCLES = TS_CYC
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // measurement chain and blocking matrix
  input  wire logic [7:0]  pf_in,
  input  wire logic        blk_in,
  input  wire logic [2:0]  param_set_sel,
  // stage outputs and events
  output pfu_outs_t        outs,
  output logic             blk_notice,
  output pfu_evt_t         evt
);

  if (MS_CYCLES < 2 || MS_CYCLES > 65535) begin : g_chk
    $error("MS_CYCLES out of range");
  end

  typedef struct packed {
    logic [15:0]                  ms_div;
    logic [2:0]                   sub;
    logic [31:0]                  ms;
    logic                         mode;
    logic                         keep_on;
    logic                         keep_off;
    logic [6:0]                   trip_thr;
    logic [6:0]                   alarm_thr;
    logic [19:0]                  trip_dly;
    logic [19:0]                  alarm_dly;
    logic [19:0]                  rel_dly;
    pfu_path_t [1:0]              path;
    logic [15:0]                  trip_ratio;
    logic [15:0]                  alarm_ratio;
    logic [HIST_DEPTH-1:0][7:0]   hist;
    pfu_outs_t                    outs;
    logic [4:0][15:0]             cnt;
    pfu_rec_t [REC_DEPTH-1:0]     rec;
    logic [3:0]                   rec_wp;
    logic [3:0]                   rec_sel;
    logic [31:0]                  rdata;
    logic                         notice;
    pfu_evt_t                     evt;
  } pfu_state_t;

  localparam logic [15:0] MS_LAST = 16'(MS_CYCLES - 1);

  pfu_state_t s_r;
  pfu_state_t s_nxt;
  logic       ms_tick;
  logic       tick;

  // millisecond stamp and 5 ms processing tick share one divider
  assign ms_tick = (s_r.ms_div == MS_LAST);
  assign tick    = ms_tick && (s_r.sub == CYC_LAST);

  function automatic logic [6:0] clamp_thr(input logic [31:0] v);
    if (v[31:7] != '0 || v[6:0] > THR_MAX) begin
      clamp_thr = THR_MAX;
    end else if (v[6:0] < THR_MIN) begin
      clamp_thr = THR_MIN;
    end else begin
      clamp_thr = v[6:0];
    end
  endfunction : clamp_thr

  function automatic logic [19:0] clamp_dly(input logic [31:0] v);
    clamp_dly = (v > 32'(DLY_MAX)) ? DLY_MAX : v[19:0];
  endfunction : clamp_dly

  // whole next-state computation; the reset value is forced at the end
  always_comb begin
    logic        blk;
    logic        en;
    logic        pick;
    logic [6:0]  thr;
    logic [19:0] dly;
    logic [19:0] cnt_n;
    logic [4:0]  old_o;
    logic [4:0]  new_o;
    logic [4:0]  rise;
    logic [4:0]  fall;
    logic [4:0]  ridx;
    pfu_rec_t    r;
    blk   = 1'b0;
    en    = 1'b0;
    pick  = 1'b0;
    thr   = '0;
    dly   = '0;
    cnt_n = '0;
    old_o = s_r.outs;
    new_o = s_r.outs;
    rise  = '0;
    fall  = '0;
    ridx  = '0;
    r     = '0;
    s_nxt = s_r;
    s_nxt.rdata  = '0;
    s_nxt.notice = 1'b0;
    s_nxt.evt    = '0;

    // time base
    s_nxt.ms_div = ms_tick ? '0 : s_r.ms_div + 16'h0001;
    if (ms_tick) begin
      s_nxt.ms  = s_r.ms + 32'h0000_0001;
      s_nxt.sub = (s_r.sub == CYC_LAST) ? '0 : s_r.sub + 3'h1;
    end

    if (tick) begin
      blk = blk_in;
      // one loop over trip path (0) and alarm path (1)
      for (int p = 0; p < 2; p++) begin
        thr = (p == 0) ? s_r.trip_thr : s_r.alarm_thr;
        dly = (p == 0) ? s_r.trip_dly : s_r.alarm_dly;
        en  = (p == 0) ? 1'b1 : s_r.mode;
        if (!en) begin
          pick = 1'b0;
        end else if (s_r.path[p].pick) begin
          // hysteresis tied to the setting, never to the measurement
          pick = (16'(pf_in) * PCT_FULL) < (16'(thr) * PCT_RELEASE);
        end else begin
          pick = pf_in < {1'b0, thr};
        end
        s_nxt.path[p].pick = pick;
        s_nxt.path[p].blk  = pick && blk;
        if (pick && !blk) begin
          // definite time only: a plain count of cycles
          cnt_n              = (s_r.path[p].cnt < dly) ? s_r.path[p].cnt + 20'h00001 : s_r.path[p].cnt;
          s_nxt.path[p].strt = 1'b1;
          s_nxt.path[p].cnt  = cnt_n;
          s_nxt.path[p].rel  = '0;
          s_nxt.path[p].op   = (cnt_n >= dly);
        end else begin
          // blocking drops start exactly like a lost pickup
          s_nxt.path[p].strt = 1'b0;
          s_nxt.path[p].op   = 1'b0;
          if (s_r.path[p].cnt != '0) begin
            if (s_r.path[p].rel + 20'h00001 >= s_r.rel_dly) begin
              s_nxt.path[p].cnt = '0;
              s_nxt.path[p].rel = '0;
            end else begin
              s_nxt.path[p].rel = s_r.path[p].rel + 20'h00001;
            end
          end
        end
      end

      // ratios refreshed every cycle
      s_nxt.trip_ratio  = 16'((16'(pf_in) * PCT_FULL) / 16'(s_r.trip_thr));
      s_nxt.alarm_ratio = 16'((16'(pf_in) * PCT_FULL) / 16'(s_r.alarm_thr));

      new_o[O_START]  = s_nxt.path[0].strt;
      new_o[O_TRIP]   = s_nxt.path[0].op;
      new_o[O_ASTART] = s_nxt.path[1].strt;
      new_o[O_ALARM]  = s_nxt.path[1].op;
      new_o[O_BLK]    = s_nxt.path[0].blk || s_nxt.path[1].blk;
      s_nxt.outs      = new_o;
      rise = new_o & ~old_o;
      fall = old_o & ~new_o;

      // all edges of one cycle leave in one event with one stamp
      s_nxt.evt.on    = s_r.keep_on ? rise : '0;
      s_nxt.evt.off   = s_r.keep_off ? fall : '0;
      s_nxt.evt.valid = (s_nxt.evt.on != '0) || (s_nxt.evt.off != '0);
      s_nxt.evt.ms    = s_r.ms;
      s_nxt.evt.pf    = pf_in;
      s_nxt.evt.fault = FAULT_3PH;
      s_nxt.notice    = rise[O_BLK];

      for (int i = 0; i < 5; i++) begin
        if (rise[i] && s_r.cnt[i] != 16'hFFFF) begin
          s_nxt.cnt[i] = s_r.cnt[i] + 16'h0001;
        end
      end

      // one record per cycle; blocked beats trip beats start
      if (rise[O_BLK] || rise[O_TRIP] || rise[O_START]) begin
        r.ms      = s_r.ms;
        r.name    = rise[O_BLK] ? REC_BLOCKED : (rise[O_TRIP] ? REC_TRIP : REC_START);
        r.pset    = param_set_sel;
        r.pf_pre  = s_r.hist[PRE_SHORT-1];
        r.pf_now  = pf_in;
        r.pf_long = s_r.hist[HIST_DEPTH-1];
        r.rem     = s_r.trip_dly - s_nxt.path[0].cnt;
        s_nxt.rec[s_r.rec_wp] = r;
        s_nxt.rec_wp = (s_r.rec_wp == REC_LAST) ? '0 : s_r.rec_wp + 4'h1;
      end

      // shift history after use so entry k holds the sample k+1 cycles old
      s_nxt.hist = {s_r.hist[HIST_DEPTH-2:0], pf_in};
    end

    // register writes
    if (reg_wr) begin
      unique case (reg_addr)
        OFS_CTRL: begin
          s_nxt.mode     = reg_wdata[CTRL_MODE];
          s_nxt.keep_on  = reg_wdata[CTRL_KEEP_ON];
          s_nxt.keep_off = reg_wdata[CTRL_KEEP_OFF];
        end
        OFS_TRIP_THR:  s_nxt.trip_thr  = clamp_thr(reg_wdata);
        OFS_ALARM_THR: s_nxt.alarm_thr = clamp_thr(reg_wdata);
        OFS_TRIP_DLY:  s_nxt.trip_dly  = clamp_dly(reg_wdata);
        OFS_ALARM_DLY: s_nxt.alarm_dly = clamp_dly(reg_wdata);
        OFS_REL_DLY:   s_nxt.rel_dly   = clamp_dly(reg_wdata);
        OFS_CNT_CLR: begin
          // clear before count, so a count in the same cycle survives
          for (int i = 0; i < 5; i++) begin
            if (reg_wdata[i]) begin
              s_nxt.cnt[i] = (tick && rise[i]) ? 16'h0001 : 16'h0000;
            end
          end
        end
        OFS_REC_SEL: s_nxt.rec_sel = (reg_wdata[31:4] != '0 || reg_wdata[3:0] > REC_LAST) ? REC_LAST : reg_wdata[3:0];
        default: ;
      endcase
    end

    // register reads, answered in the next cycle; unmapped reads zero
    if (reg_rd) begin
      ridx = 5'(s_r.rec_wp) + 5'(REC_LAST) - 5'(s_r.rec_sel);
      if (ridx >= 5'(REC_DEPTH)) begin
        ridx = ridx - 5'(REC_DEPTH);
      end
      unique case (reg_addr)
        OFS_CTRL:      s_nxt.rdata = {29'h0, s_r.keep_off, s_r.keep_on, s_r.mode};
        OFS_TRIP_THR:  s_nxt.rdata = {25'h0, s_r.trip_thr};
        OFS_ALARM_THR: s_nxt.rdata = {25'h0, s_r.alarm_thr};
        OFS_TRIP_DLY:  s_nxt.rdata = {12'h0, s_r.trip_dly};
        OFS_ALARM_DLY: s_nxt.rdata = {12'h0, s_r.alarm_dly};
        OFS_REL_DLY:   s_nxt.rdata = {12'h0, s_r.rel_dly};
        OFS_STATUS: begin
          s_nxt.rdata[8:4] = s_r.outs;
          if (s_r.outs.trip) begin
            s_nxt.rdata[2:0] = ST_TRIP;
          end else if (s_r.outs.alarm) begin
            s_nxt.rdata[2:0] = ST_ALARM;
          end else if (s_r.outs.start) begin
            s_nxt.rdata[2:0] = ST_START;
          end else if (s_r.outs.alarm_start) begin
            s_nxt.rdata[2:0] = ST_ASTART;
          end else if (s_r.outs.blocked) begin
            s_nxt.rdata[2:0] = ST_BLOCKED;
          end else begin
            s_nxt.rdata[2:0] = ST_NORMAL;
          end
        end
        OFS_RATIO: s_nxt.rdata = {s_r.alarm_ratio, s_r.trip_ratio};
        // remaining time in 5 ms steps, trip sign extended, alarm zero extended
        OFS_TRIP_REM: s_nxt.rdata = s_r.path[0].strt ?
          32'(signed'({1'b0, s_r.trip_dly}) - signed'({1'b0, s_r.path[0].cnt})) : '0;
        OFS_ALARM_REM: s_nxt.rdata = s_r.path[1].strt ? {12'h0, s_r.alarm_dly - s_r.path[1].cnt} : '0;
        OFS_REC_SEL:   s_nxt.rdata = {28'h0, s_r.rec_sel};
        OFS_REC_TS:    s_nxt.rdata = s_r.rec[ridx[3:0]].ms;
        OFS_REC_PF:    s_nxt.rdata = {1'b0, s_r.rec[ridx[3:0]].pset, s_r.rec[ridx[3:0]].name, 2'h0,
          s_r.rec[ridx[3:0]].pf_long, s_r.rec[ridx[3:0]].pf_now, s_r.rec[ridx[3:0]].pf_pre};
        OFS_REC_REM:   s_nxt.rdata = {12'h0, s_r.rec[ridx[3:0]].rem};
        default: begin
          for (int i = 0; i < 5; i++) begin
            if (reg_addr == OFS_CNT0 + 8'(4 * i)) begin
              s_nxt.rdata = {16'h0, s_r.cnt[i]};
            end
          end
        end
      endcase
    end

    if (sys_rst) begin
      s_nxt           = '0;
      s_nxt.mode      = MODE_RST;
      s_nxt.keep_on   = KEEP_ON_RST;
      s_nxt.keep_off  = KEEP_OFF_RST;
      s_nxt.trip_thr  = TRIP_THR_RST;
      s_nxt.alarm_thr = ALARM_THR_RST;
      s_nxt.trip_dly  = DLY_RST;
      s_nxt.alarm_dly = DLY_RST;
      s_nxt.rel_dly   = DLY_RST;
    end
  end

  // one register for the whole state
  always_ff @(posedge clk) begin
    s_r <= s_nxt;
  end

  assign reg_rdata  = s_r.rdata;
  assign outs       = s_r.outs;
  assign blk_notice = s_r.notice;
  assign evt        = s_r.evt;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  start_unblocked_a: assert property (tick && blk_in |=> !outs.start && !outs.alarm_start)
    else $error("start raised while blocked");
  blocked_pick_a: assert property (tick && blk_in && pf_in < {1'b0, s_r.trip_thr} |=> outs.blocked)
    else $error("blocked missing on pickup under blocking");
  alarm_mode_a: assert property (!s_r.mode && tick |=> !outs.alarm && !outs.alarm_start)
    else $error("alarm output outside alarm mode");
  hyst_hold_a: assert property (tick && s_r.path[0].pick && !blk_in
                                && (16'(pf_in) * PCT_FULL) < (16'(s_r.trip_thr) * PCT_RELEASE) |=> outs.start)
    else $error("start released inside hysteresis band");
  instant_trip_a: assert property ($rose(outs.start) && s_r.trip_dly == '0 |-> outs.trip
                                   && evt.on[O_START] == s_r.keep_on && evt.on[O_TRIP] == s_r.keep_on)
    else $error("instant start and trip not together");
  trip_delay_a: assert property ($rose(outs.trip) && s_r.trip_dly != '0 |-> s_r.path[0].cnt == s_r.trip_dly)
    else $error("trip before definite delay");
  notice_blk_a: assert property ($rose(outs.blocked) |-> blk_notice && evt.fault == FAULT_3PH)
    else $error("blocking notice missing");
  ms_stamp_a: assert property (ms_tick |=> s_r.ms == $past(s_r.ms) + 32'h0000_0001)
    else $error("millisecond stamp not advanced");
  trip_count_a: assert property ($rose(outs.trip) && $past(s_r.cnt[O_TRIP]) != 16'hFFFF
                                 |-> s_r.cnt[O_TRIP] == $past(s_r.cnt[O_TRIP]) + 16'h0001)
    else $error("trip counter not advanced");
  rec_write_a: assert property (s_r.rec_wp != $past(s_r.rec_wp)
                                |-> $rose(outs.start) || $rose(outs.trip) || $rose(outs.blocked))
    else $error("record written without ON edge");
  status_trip_a: assert property (reg_rd && reg_addr == OFS_STATUS && outs.trip |=> reg_rdata[2:0] == ST_TRIP)
    else $error("status code not trip");

  trip_seen_c: cover property ($rose(outs.trip));
  blocked_seen_c: cover property ($rose(outs.blocked));
  alarm_seen_c: cover property ($rose(outs.alarm));
  block_drop_c: cover property (outs.start ##1 tick && blk_in ##1 !outs.start);

endmodule : pfu_low_pf_stage

/* pfu_meas_model.sv */
module pfu_meas_model
  import pfu_pkg::*;
(
  // clock
  input  wire logic       clk,
  // values asked for by the bench
  input  wire logic [7:0] pf_want,
  input  wire logic       blk_want,
  input  wire logic [2:0] set_want,
  // toward the stage
  output logic      [7:0] pf_in,
  output logic            blk_in,
  output logic      [2:0] param_set_sel
);
  timeunit 1ns;
  timeprecision 1ps;

  // chain output moves only after an edge; bench holds each value over whole cycles
  always_ff @(posedge clk) begin
    pf_in         <= pf_want;
    blk_in        <= blk_want;
    param_set_sel <= set_want;
  end
endmodule : pfu_meas_model

/* testbench.sv */
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import pfu_pkg::*;

  // short millisecond keeps one processing cycle at 20 clocks
  localparam int unsigned MS   = 4;
  localparam int unsigned TICK = 5 * MS;

  logic        clk       = 1'b0;
  logic        sys_rst   = 1'b1;
  logic [7:0]  reg_addr  = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic [7:0]  pf_want   = 8'h5F;
  logic        blk_want  = 1'b0;
  logic [2:0]  set_want  = 3'h5;
  logic [31:0] reg_rdata, rd;
  logic [7:0]  pf_in;
  logic        blk_in, blk_notice;
  logic [2:0]  param_set_sel;
  logic [4:0]  last_on;
  logic [7:0]  last_pf;
  logic [1:0]  last_flt;
  pfu_outs_t   outs;
  pfu_evt_t    evt;
  int          num_errors = 0;
  int          checks     = 0;
  int          evt_cnt    = 0;
  int          notices    = 0;
  int          n, c;
  logic        tp, ap;
  logic [7:0]  pv;

  `define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin num_errors++; \
    $display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end

  always #12.5 clk = ~clk;

  pfu_meas_model u_meas (.clk(clk), .pf_want(pf_want), .blk_want(blk_want), .set_want(set_want),
    .pf_in(pf_in), .blk_in(blk_in), .param_set_sel(param_set_sel));

  pfu_low_pf_stage #(.MS_CYCLES(MS)) DUT (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pf_in(pf_in),
    .blk_in(blk_in), .param_set_sel(param_set_sel), .outs(outs), .blk_notice(blk_notice), .evt(evt));

  // event and notice pulses last one cycle, so they are tallied here
  always @(posedge clk) begin
    if (evt.valid === 1'b1) begin
      evt_cnt  <= evt_cnt + 1;
      last_on  <= evt.on;
      last_pf  <= evt.pf;
      last_flt <= evt.fault;
    end
    if (blk_notice === 1'b1) begin
      notices <= notices + 1;
    end
  end

  // hysteresis referenced to the setting, never to the measurement
  function automatic logic pick(input logic was, input int pf, input int thr);
    return was ? (pf * 100 < thr * 103) : (pf < thr);
  endfunction : pick

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask : wr

  // data stands only in the cycle after the strobe edge
  task automatic rdr(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask : rdr

  // two whole processing cycles so a tick always sees the new inputs
  task automatic step(input logic [7:0] pf, input logic blk);
    @(posedge clk);
    pf_want  <= pf;
    blk_want <= blk;
    repeat (2 * TICK) @(posedge clk);
    #1;
  endtask : step

  task automatic final_report;
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : final_report

  initial begin
    void'($urandom(32'h3B82205A));
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    rdr(OFS_CTRL, rd);
    `CHK("ctrl", 32'h7, rd)
    rdr(OFS_TRIP_THR, rd);
    `CHK("trip_thr", 32'(TRIP_THR_RST), rd)
    rdr(OFS_ALARM_THR, rd);
    `CHK("alarm_thr", 32'(ALARM_THR_RST), rd)
    rdr(8'hFC, rd);
    `CHK("unmapped", 32'h0, rd)
    wr(OFS_TRIP_THR, 32'h2);
    rdr(OFS_TRIP_THR, rd);
    `CHK("thr_low", 32'h5, rd)
    wr(OFS_TRIP_THR, 32'h50);
    $display("test registers done");
    // corners first, then random samples
    tp = 1'b0;
    ap = 1'b0;
    for (int i = 0; i < 20; i++) begin
      pv = (i < 8) ? 8'(i[0] ? 83 - i / 2 : 79 + 4 * (i / 2)) : 8'($urandom_range(98, 72));
      step(pv, 1'b0);
      tp = pick(tp, pv, 80);
      ap = pick(ap, pv, 90);
      `CHK("outs_rand", {1'b0, tp, tp, ap, ap}, outs)
    end
    step(8'h5F, 1'b0);
    `CHK("outs_idle", 5'h00, outs)
    $display("test hysteresis done");
    wr(OFS_CNT_CLR, 32'h1F);
    c = evt_cnt;
    step(8'h46, 1'b0);
    `CHK("outs_trip", 5'h0F, outs)
    `CHK("evt_on", 5'h0F, last_on)
    `CHK("evt_one", c + 1, evt_cnt)
    `CHK("evt_fault", FAULT_3PH, last_flt)
    `CHK("evt_pf", 8'h46, last_pf)
    rdr(OFS_STATUS, rd);
    `CHK("st_trip", ST_TRIP, rd[2:0])
    rdr(OFS_RATIO, rd);
    `CHK("ratio", {16'h004D, 16'h0057}, rd)
    rdr(OFS_CNT0 + 8'h0C, rd);
    `CHK("trip_cnt", 32'h1, rd)
    wr(OFS_REC_SEL, 32'h0);
    rdr(OFS_REC_PF, rd);
    `CHK("rec_name", REC_TRIP, rd[27:26])
    `CHK("rec_set", 3'h5, rd[30:28])
    `CHK("rec_pf", 8'h46, rd[15:8])
    step(8'h5F, 1'b0);
    wr(OFS_CTRL, 32'h6);
    step(8'h55, 1'b0);
    `CHK("mode0", 5'h00, outs)
    wr(OFS_CTRL, 32'h5);
    c = evt_cnt;
    step(8'h46, 1'b0);
    `CHK("keep_on", c, evt_cnt)
    step(8'h5F, 1'b0);
    `CHK("keep_off", c + 1, evt_cnt)
    wr(OFS_CTRL, 32'h7);
    $display("test trip and events done");
    step(8'h46, 1'b1);
    `CHK("blk_outs", 5'h10, outs)
    `CHK("notice", 1'b1, notices > 0)
    rdr(OFS_STATUS, rd);
    `CHK("st_blk", ST_BLOCKED, rd[2:0])
    step(8'h5F, 1'b0);
    step(8'h46, 1'b0);
    step(8'h46, 1'b1);
    `CHK("blk_drop", 4'h0, outs[3:0])
    step(8'h5F, 1'b0);
    $display("test blocking done");
    wr(OFS_ALARM_DLY, 32'd50);
    step(8'h55, 1'b0);
    `CHK("astart", 5'h01, outs)
    rdr(OFS_STATUS, rd);
    `CHK("st_astart", ST_ASTART, rd[2:0])
    rdr(OFS_ALARM_REM, rd);
    `CHK("alarm_rem", 1'b1, rd > 0 && rd <= 50)
    rdr(OFS_ALARM_DLY, rd);
    `CHK("alarm_dly", 32'd50, rd)
    wr(OFS_ALARM_DLY, 32'h0);
    step(8'h5F, 1'b0);
    wr(OFS_CTRL, 32'h6);
    wr(OFS_TRIP_DLY, 32'h4);
    @(posedge clk);
    pf_want <= 8'h46;
    // look just after each edge so the launching edge is not raced
    for (n = 0; n < 3 * TICK && outs.start !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    if (outs.start !== 1'b1) num_errors++;
    rdr(OFS_STATUS, rd);
    `CHK("st_start", ST_START, rd[2:0])
    rdr(OFS_TRIP_REM, rd);
    `CHK("trip_rem", 1'b1, $signed(rd) > 0 && $signed(rd) <= 4)
    for (n = 4; n < 10 * TICK && outs.trip !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    `CHK("trip_delay", 3 * TICK, n)
    $display("test delays done");
    final_report();
  end

  // hang guard
  initial begin
    repeat (90000) @(posedge clk);
    num_errors++;
    final_report();
  end
endmodule : testbench
